// ### rtl/sdb_entry_cmp.sv
// first-stage match and bypass legality for one store buffer entry
module sdb_entry_cmp
  import sdb_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire logic     srst,
  input  wire sdb_ent_t ent,
  input  wire sdb_acc_t ld,
  output logic          hit,
  output logic          legal,
  output logic          upper
);
  logic same_lo;
  logic both_al;
  logic dw_ov;

  // only bits 11:4 and the doubleword mask: cheap, may alias
  assign dw_ov   = |(sdb_dw_mask(ent.acc) & sdb_dw_mask(ld));
  assign hit     = ent.valid && dw_ov &&
                   (ent.acc.addr[S1_HI:S1_LO] == ld.addr[S1_HI:S1_LO]);
  assign same_lo = ent.acc.addr[S1_HI:0] == ld.addr[S1_HI:0];
  assign both_al = sdb_aligned(ent.acc) && sdb_aligned(ld);
  assign upper   = (ent.acc.size == SDB_SZ_O) && (ld.size <= SDB_SZ_Q) &&
                   (ld.addr[BANK_HI:0] == UPPER_QW_OFS) &&
                   (ent.acc.addr[S1_HI:S1_LO] == ld.addr[S1_HI:S1_LO]);
  // wider aligned store feeds a narrower load at the same start
  assign legal   = hit && both_al && !ent.shared &&
                   ((same_lo && (ld.size <= ent.acc.size)) || upper);

  a_align_gate: assert property (@(posedge sys_clk) disable iff (srst)
    legal |-> sdb_aligned(ent.acc) && sdb_aligned(ld))
    else $error("bypass allowed on misaligned access");
  a_size_gate: assert property (@(posedge sys_clk) disable iff (srst)
    legal && !upper |-> ld.size <= ent.acc.size)
    else $error("bypass to wider load");
  a_start_gate: assert property (@(posedge sys_clk) disable iff (srst)
    legal |-> same_lo || (ld.addr[BANK_HI:0] == UPPER_QW_OFS && ent.acc.size == SDB_SZ_O))
    else $error("bypass with mismatched start");
  a_dw_match: assert property (@(posedge sys_clk) disable iff (srst)
    hit |-> (sdb_dw_mask(ent.acc) & sdb_dw_mask(ld)) != '0)
    else $error("first stage hit without doubleword overlap");
  a_shared_block: assert property (@(posedge sys_clk) disable iff (srst)
    ent.shared |-> !legal)
    else $error("bypass from entry sharing its doubleword");
endmodule

// ### rtl/sdb_forward_check.sv
// store data bypass decision: store buffer, two-stage match, wait and retry
//
// Overview of operation
// - no bypass unless start addresses match, except the upper-quadword case
// - aligned wider store feeds same-start load
// - aligned 128-bit store feeds upper-quadword load
// - misaligned store or load never bypasses
// - 128-bit load never assembled from quadwords
// - distinct narrow stores in dword block: only the younger bypasses
// - older narrow store blocked, younger still bypasses
// - single narrow store and load may bypass
// - byte from word, word from dword allowed
// - first stage compares address bits 11:4
// - first stage also needs same doubleword
// - first stage legal hit starts bypass speculatively
// - second stage bits 47:12 confirm bypass
// - second stage mismatch cancels load for retry
// - load wider than store never bypasses
// - blocked load waits for store retire
module sdb_forward_check
  import sdb_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic              ce,
  input  wire logic              st_push,
  input  wire sdb_acc_t          st_acc,
  input  wire logic [DATA_W-1:0] st_data,
  output logic                   st_ready,
  input  wire logic              st_retire,
  input  wire logic              ld_valid,
  input  wire sdb_acc_t          ld_acc,
  output logic                   ld_ready,
  output logic                   fwd_spec,
  output logic                   fwd_valid,
  output logic [DATA_W-1:0]      fwd_data,
  output logic                   ld_cancel,
  output logic                   ld_block,
  output logic                   ld_cache_rd
);
  sdb_ent_t          ent_r [SDB_ENTRIES];
  logic [DATA_W-1:0] data_r [SDB_ENTRIES];
  logic [IDX_W-1:0]  head_r;
  logic [IDX_W-1:0]  tail_r;
  logic [CNT_W-1:0]  count_r;
  sdb_state_t        state_r;
  logic [IDX_W-1:0]  wait_idx_r;

  logic [SDB_ENTRIES-1:0] hit_v;
  logic [SDB_ENTRIES-1:0] legal_v;
  logic [SDB_ENTRIES-1:0] upper_v;

  logic              push_ok;
  logic              retire_ok;
  logic              ld_take;
  logic              any_hit;
  logic [IDX_W-1:0]  sel_idx;
  logic              sel_legal;
  logic              sel_upper;

  logic              s1_vld_r;
  logic              s1_hit_r;
  logic              s1_legal_r;
  logic              s1_upper_r;
  logic [IDX_W-1:0]  s1_idx_r;
  sdb_acc_t          s1_ld_r;

  logic              s2_ent_ok;
  logic              s2_hi_eq;
  logic [DATA_W-1:0] s2_shift;
  logic [DATA_W-1:0] s2_mask;

  assign st_ready  = count_r != CNT_W'(SDB_ENTRIES);
  assign push_ok   = ce && st_push && st_ready;
  assign retire_ok = ce && st_retire && (count_r != '0);
  // one load in flight at a time keeps the stage registers simple
  assign ld_ready  = (state_r == SDB_IDLE) && !s1_vld_r;
  assign ld_take   = ce && ld_valid && ld_ready;

  genvar g;
  generate
    for (g = 0; g < SDB_ENTRIES; g++) begin : g_cmp
      sdb_entry_cmp u_cmp (
        .sys_clk (sys_clk),
        .srst    (srst),
        .ent     (ent_r[g]),
        .ld      (ld_acc),
        .hit     (hit_v[g]),
        .legal   (legal_v[g]),
        .upper   (upper_v[g])
      );
    end
  endgenerate

  // youngest overlapping store decides; walk oldest to newest
  always_comb begin
    logic [IDX_W-1:0] k;
    k         = '0;
    any_hit   = 1'b0;
    sel_idx   = '0;
    sel_legal = 1'b0;
    sel_upper = 1'b0;
    for (int i = 0; i < SDB_ENTRIES; i++) begin
      k = head_r + IDX_W'(i);
      if (hit_v[k]) begin
        any_hit   = 1'b1;
        sel_idx   = k;
        sel_legal = legal_v[k];
        sel_upper = upper_v[k];
      end
    end
  end

  // speculative start before the upper bits are known
  assign fwd_spec = ld_take && any_hit && sel_legal;

  // store buffer allocation and retire
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      head_r  <= '0;
      tail_r  <= '0;
      count_r <= '0;
    end else if (ce) begin
      if (push_ok) begin
        tail_r <= tail_r + IDX_W'(1);
      end
      if (retire_ok) begin
        head_r <= head_r + IDX_W'(1);
      end
      count_r <= count_r + CNT_W'(push_ok) - CNT_W'(retire_ok);
    end
  end

  generate
    for (g = 0; g < SDB_ENTRIES; g++) begin : g_ent
      logic narrow_pair;
      assign narrow_pair = ent_r[g].valid &&
                           (ent_r[g].acc.size <= SDB_SZ_W) && (st_acc.size <= SDB_SZ_W) &&
                           (ent_r[g].acc.addr[ADDR_W-1:DW_LO] ==
                            st_acc.addr[ADDR_W-1:DW_LO]) &&
                           (ent_r[g].acc.addr[NARROW_HI:0] != st_acc.addr[NARROW_HI:0]);
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          ent_r[g] <= '0;
        end else if (ce) begin
          if (push_ok && tail_r == IDX_W'(g)) begin
            ent_r[g].valid  <= 1'b1;
            ent_r[g].shared <= 1'b0;
            ent_r[g].acc    <= st_acc;
          end else if (retire_ok && head_r == IDX_W'(g)) begin
            ent_r[g].valid  <= 1'b0;
          end else if (push_ok && narrow_pair) begin
            // older narrow store now shares its doubleword: stop feeding
            ent_r[g].shared <= 1'b1;
          end
        end
      end
      // payload needs no reset; only read while valid
      always_ff @(posedge sys_clk) begin
        if (ce && push_ok && tail_r == IDX_W'(g)) begin
          data_r[g] <= st_data;
        end
      end
    end
  endgenerate

  // first stage result held for the upper address check
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1_vld_r   <= 1'b0;
      s1_hit_r   <= 1'b0;
      s1_legal_r <= 1'b0;
      s1_upper_r <= 1'b0;
      s1_idx_r   <= '0;
      s1_ld_r    <= '0;
    end else if (ce) begin
      s1_vld_r <= ld_take;
      if (ld_take) begin
        s1_hit_r   <= any_hit;
        s1_legal_r <= sel_legal;
        s1_upper_r <= sel_upper;
        s1_idx_r   <= sel_idx;
        s1_ld_r    <= ld_acc;
      end
    end
  end

  // entry retired between stages, or retiring now: the cache holds it
  assign s2_ent_ok = ent_r[s1_idx_r].valid &&
                     !(retire_ok && (head_r == s1_idx_r));
  assign s2_hi_eq  = ent_r[s1_idx_r].acc.addr[S2_HI:S2_LO] ==
                     s1_ld_r.addr[S2_HI:S2_LO];
  // upper quadword case reads the top half of the 128-bit entry
  assign s2_shift  = s1_upper_r ? (data_r[s1_idx_r] >> QW_W) : data_r[s1_idx_r];

  always_comb begin
    s2_mask = '0;
    unique case (s1_ld_r.size)
      SDB_SZ_B: s2_mask = {{(DATA_W-BYTE_W){1'b0}}, {BYTE_W{1'b1}}};
      SDB_SZ_W: s2_mask = {{(DATA_W-2*BYTE_W){1'b0}}, {(2*BYTE_W){1'b1}}};
      SDB_SZ_D: s2_mask = {{(DATA_W-4*BYTE_W){1'b0}}, {(4*BYTE_W){1'b1}}};
      SDB_SZ_Q: s2_mask = {{(DATA_W-QW_W){1'b0}}, {QW_W{1'b1}}};
      SDB_SZ_O: s2_mask = {DATA_W{1'b1}};
      default:  s2_mask = '0;
    endcase
  end

  // second stage outcome per load, and the cache read when a waiting load is released
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      fwd_valid   <= 1'b0;
      fwd_data    <= '0;
      ld_cancel   <= 1'b0;
      ld_block    <= 1'b0;
      ld_cache_rd <= 1'b0;
    end else if (ce) begin
      fwd_valid   <= 1'b0;
      ld_cancel   <= 1'b0;
      ld_block    <= 1'b0;
      ld_cache_rd <= 1'b0;
      if (s1_vld_r) begin
        if (!s1_hit_r || !s2_ent_ok) begin
          ld_cache_rd <= 1'b1;
        end else if (!s2_hi_eq) begin
          // aliased on low bits only: the load goes back for reissue
          ld_cancel <= 1'b1;
        end else if (s1_legal_r) begin
          fwd_valid <= 1'b1;
          fwd_data  <= s2_shift & s2_mask;
        end else begin
          ld_block <= 1'b1;
        end
      end else if (state_r == SDB_WAIT && retire_ok && head_r == wait_idx_r) begin
        ld_cache_rd <= 1'b1;
      end
    end
  end

  // true dependency that cannot bypass: hold until that store retires
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r    <= SDB_IDLE;
      wait_idx_r <= '0;
    end else if (ce) begin
      unique case (state_r)
        SDB_IDLE: begin
          if (s1_vld_r && s1_hit_r && s2_ent_ok && s2_hi_eq && !s1_legal_r) begin
            state_r    <= SDB_WAIT;
            wait_idx_r <= s1_idx_r;
          end
        end
        SDB_WAIT: begin
          if (retire_ok && head_r == wait_idx_r) begin
            state_r <= SDB_IDLE;
          end
        end
      endcase
    end
  end

  sequence s_spec_start;
    ce && fwd_spec ##1 ce;
  endsequence

  sequence s_s2_true;
    ce && s1_vld_r && s1_hit_r && s2_ent_ok && s2_hi_eq;
  endsequence

  // waiting on a store that retires in the same cycle would never release
  sequence s_stage2_retire;
    ce && s1_vld_r && s1_hit_r && retire_ok && (head_r == s1_idx_r);
  endsequence

  a_spec_resolve: assert property (@(posedge sys_clk) disable iff (srst)
    s_spec_start |=> (fwd_valid || ld_cancel || ld_cache_rd) && !ld_block)
    else $error("speculative bypass not resolved");
  a_hi_confirm: assert property (@(posedge sys_clk) disable iff (srst)
    s_s2_true and s1_legal_r |=> fwd_valid && !ld_cancel)
    else $error("confirmed bypass did not complete");
  a_hi_cancel: assert property (@(posedge sys_clk) disable iff (srst)
    ce && s1_vld_r && s1_hit_r && s2_ent_ok && !s2_hi_eq |=> ld_cancel && !fwd_valid)
    else $error("false bypass not cancelled");
  a_no_hit_cache: assert property (@(posedge sys_clk) disable iff (srst)
    ce && ld_take && !any_hit ##1 ce |=> ld_cache_rd && !ld_block)
    else $error("load without overlap not sent to cache");
  a_block_wait: assert property (@(posedge sys_clk) disable iff (srst)
    ce && ld_block |-> state_r == SDB_WAIT && !ld_ready)
    else $error("blocked load not held");
  a_wait_release: assert property (@(posedge sys_clk) disable iff (srst)
    ce && state_r == SDB_WAIT && retire_ok && head_r == wait_idx_r
    |=> ld_cache_rd && state_r == SDB_IDLE)
    else $error("waiting load not released on retire");
  a_retire_race: assert property (@(posedge sys_clk) disable iff (srst)
    s_stage2_retire |=> ld_cache_rd && !ld_block && state_r == SDB_IDLE)
    else $error("retired store left a load waiting");
  a_fwd_from_legal: assert property (@(posedge sys_clk) disable iff (srst)
    fwd_valid && $past(ce) |-> $past(s1_legal_r) && $past(s2_hi_eq))
    else $error("bypass without legal match");
  a_wide_load_block: assert property (@(posedge sys_clk) disable iff (srst)
    ce && ld_take && any_hit && ld_acc.size == SDB_SZ_O &&
    ent_r[sel_idx].acc.size != SDB_SZ_O |-> !fwd_spec)
    else $error("128-bit load fed from narrower store");
endmodule

// ### rtl/sdb_pkg.sv
// shared constants, types and helpers for the store data bypass check
package sdb_pkg;
  localparam int SDB_ENTRIES = 8;
  localparam int IDX_W       = 3;
  localparam int CNT_W       = 4;
  localparam int ADDR_W      = 48;
  localparam int DATA_W      = 128;
  localparam int QW_W        = 64;
  localparam int BYTE_W      = 8;
  localparam int S1_LO       = 4;
  localparam int S1_HI       = 11;
  localparam int S2_LO       = 12;
  localparam int S2_HI       = 47;
  localparam int BANK_HI     = 3;
  localparam int DW_LO       = 2;
  localparam int DW_HI       = 3;
  localparam int NARROW_HI   = 1;
  localparam int NUM_DW      = 4;
  localparam logic [3:0] UPPER_QW_OFS = 4'h8;
  localparam logic [3:0] BANK_ZERO    = 4'h0;

  // operand size as log2 of its byte count
  typedef enum logic [2:0] {
    SDB_SZ_B,
    SDB_SZ_W,
    SDB_SZ_D,
    SDB_SZ_Q,
    SDB_SZ_O
  } sdb_size_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    sdb_size_t         size;
  } sdb_acc_t;

  typedef struct packed {
    logic     valid;
    logic     shared;
    sdb_acc_t acc;
  } sdb_ent_t;

  typedef enum logic {
    SDB_IDLE,
    SDB_WAIT
  } sdb_state_t;

  function automatic logic sdb_aligned(input sdb_acc_t a);
    logic [4:0] m;
    m = (5'h01 << a.size) - 5'h01;
    return (a.addr[BANK_HI:0] & m[BANK_HI:0]) == BANK_ZERO;
  endfunction

  // which doublewords of the 16-byte bank the access touches
  function automatic logic [NUM_DW-1:0] sdb_dw_mask(input sdb_acc_t a);
    logic [4:0]        s;
    logic [4:0]        e;
    logic [NUM_DW-1:0] m;
    s = {1'b0, a.addr[BANK_HI:0]};
    e = s + ((5'h01 << a.size) - 5'h01);
    for (int d = 0; d < NUM_DW; d++) begin
      m[d] = (5'(d * 4) <= e) && (5'(d * 4 + 3) >= s);
    end
    return m;
  endfunction
endpackage

// ### tb/slfc_lsu_model.sv
// load/store pipeline model issuing stores, retires and loads
module slfc_lsu_model
  import sdb_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         st_ready,
  input  wire logic         ld_ready,
  input  wire logic         fwd_spec,
  output logic              st_push,
  output sdb_acc_t          st_acc,
  output logic [DATA_W-1:0] st_data,
  output logic              st_retire,
  output logic              ld_valid,
  output sdb_acc_t          ld_acc
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    st_push   = 1'b0;
    st_acc    = '0;
    st_data   = '0;
    st_retire = 1'b0;
    ld_valid  = 1'b0;
    ld_acc    = '0;
  end

  // idle lines show inverted data so stale values never look valid
  task automatic push(input logic [ADDR_W-1:0] a, input sdb_size_t s,
                      input logic [DATA_W-1:0] d);
    @(negedge sys_clk);
    st_push = 1'b1;
    st_acc  = '{addr: a, size: s};
    st_data = d;
    @(negedge sys_clk);
    st_push     = 1'b0;
    st_acc.addr = ~a;
    st_data     = ~d;
  endtask

  task automatic retire();
    @(negedge sys_clk);
    st_retire = 1'b1;
    @(negedge sys_clk);
    st_retire = 1'b0;
  endtask

  // returns in the cycle where the load result pulses
  task automatic load(input logic [ADDR_W-1:0] a, input sdb_size_t s, output logic spec);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (!ld_ready && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    ld_valid = 1'b1;
    ld_acc   = '{addr: a, size: s};
    #5;
    spec = fwd_spec;
    @(negedge sys_clk);
    ld_valid    = 1'b0;
    ld_acc.addr = ~a;
    @(negedge sys_clk);
  endtask
endmodule

// ### tb/store_load_forward_check_tb.sv
// self-checking bench for the store data bypass decision block
module store_load_forward_check_tb;
  import sdb_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [4:0] FWD = 5'h18;
  localparam logic [4:0] CAN = 5'h14;
  localparam logic [4:0] BLK = 5'h02;
  localparam logic [4:0] CRD = 5'h01;
  localparam logic [4:0] NON = 5'h00;
  localparam logic [DATA_W-1:0] D0 = 128'hfedc_ba98_7654_3210_0f1e_2d3c_4b5a_6978;

  logic sys_clk, srst, ce, st_push, st_ready, st_retire, ld_valid, ld_ready;
  logic fwd_spec, fwd_valid, ld_cancel, ld_block, ld_cache_rd, sp;
  logic [DATA_W-1:0] st_data, fwd_data;
  sdb_acc_t          st_acc, ld_acc;
  int                errors, tests_run;

  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;

  sdb_forward_check uut (
    .sys_clk(sys_clk), .srst(srst), .ce(ce), .st_push(st_push), .st_acc(st_acc),
    .st_data(st_data), .st_ready(st_ready), .st_retire(st_retire), .ld_valid(ld_valid),
    .ld_acc(ld_acc), .ld_ready(ld_ready), .fwd_spec(fwd_spec), .fwd_valid(fwd_valid),
    .fwd_data(fwd_data), .ld_cancel(ld_cancel), .ld_block(ld_block),
    .ld_cache_rd(ld_cache_rd)
  );

  slfc_lsu_model u_lsu (
    .sys_clk(sys_clk), .st_ready(st_ready), .ld_ready(ld_ready), .fwd_spec(fwd_spec),
    .st_push(st_push), .st_acc(st_acc), .st_data(st_data), .st_retire(st_retire),
    .ld_valid(ld_valid), .ld_acc(ld_acc)
  );

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_res(input logic [4:0] got, input logic [4:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s result %b expected %b", $time, m, got, exp);
    end
  endtask

  task automatic chk_data(input logic [DATA_W-1:0] exp, input string m);
    tests_run++;
    if (fwd_data !== exp) begin
      errors++;
      $display("wrong value at %0t: %s data %h expected %h", $time, m, fwd_data, exp);
    end
  endtask

  task automatic chk_rdy(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s ready %b expected %b", $time, m, got, exp);
    end
  endtask

  // bytes ofs..ofs+n-1 of store data, moved to byte 0, zero above
  function automatic logic [DATA_W-1:0] msk(input logic [DATA_W-1:0] d, input int ofs,
                                            input int n);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int i = 0; i < n; i++) m[i*8+:8] = d[(ofs+i)*8+:8];
    return m;
  endfunction

  task automatic ld(input logic [ADDR_W-1:0] a, input sdb_size_t s, input logic [4:0] exp,
                    input string m);
    u_lsu.load(a, s, sp);
    chk_res({sp, fwd_valid, ld_cancel, ld_block, ld_cache_rd}, exp, m);
  endtask

  task automatic rt(input logic [4:0] exp, input string m);
    u_lsu.retire();
    chk_res({1'b0, fwd_valid, ld_cancel, ld_block, ld_cache_rd}, exp, m);
  endtask

  // short reset between scenarios empties the buffer
  task automatic rst();
    @(negedge sys_clk);
    srst = 1'b1;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
  endtask

  task automatic t_same();
    rst();
    u_lsu.push(48'h0000_0000_0100, SDB_SZ_D, D0);
    ld(48'h0000_0000_0100, SDB_SZ_D, FWD, "same dword");
    chk_data(msk(D0, 0, 4), "same dword");
    $display("test same_size done");
  endtask

  task automatic t_wide();
    rst();
    u_lsu.push(48'h0000_0000_0208, SDB_SZ_Q, D0);
    u_lsu.push(48'h0000_0000_0220, SDB_SZ_W, ~D0);
    u_lsu.push(48'h0000_0000_0230, SDB_SZ_D, D0);
    ld(48'h0000_0000_0208, SDB_SZ_W, FWD, "word from quad");
    chk_data(msk(D0, 0, 2), "word from quad");
    ld(48'h0000_0000_0220, SDB_SZ_B, FWD, "byte from word");
    chk_data(msk(~D0, 0, 1), "byte from word");
    ld(48'h0000_0000_0230, SDB_SZ_W, FWD, "word from dword");
    chk_data(msk(D0, 0, 2), "word from dword");
    $display("test wide_to_narrow done");
  endtask

  task automatic t_upper();
    rst();
    u_lsu.push(48'h0000_0000_0300, SDB_SZ_O, D0);
    ld(48'h0000_0000_0308, SDB_SZ_Q, FWD, "upper quad");
    chk_data(msk(D0, 8, 8), "upper quad");
    ld(48'h0000_0000_030c, SDB_SZ_D, BLK, "offset start");
    chk_rdy(ld_ready, 1'b0, "held while blocked");
    rt(CRD, "retire releases load");
    chk_rdy(ld_ready, 1'b1, "released after retire");
    $display("test upper_quad done");
  endtask

  task automatic t_block();
    rst();
    u_lsu.push(48'h0000_0000_0404, SDB_SZ_Q, D0);
    ld(48'h0000_0000_0404, SDB_SZ_Q, BLK, "misaligned");
    rt(CRD, "misaligned release");
    u_lsu.push(48'h0000_0000_0500, SDB_SZ_W, D0);
    ld(48'h0000_0000_0500, SDB_SZ_D, BLK, "narrow to wide");
    rt(CRD, "narrow release");
    $display("test blocked done");
  endtask

  task automatic t_oword();
    rst();
    u_lsu.push(48'h0000_0000_0600, SDB_SZ_Q, D0);
    u_lsu.push(48'h0000_0000_0608, SDB_SZ_Q, ~D0);
    ld(48'h0000_0000_0600, SDB_SZ_O, BLK, "two quads");
    rt(NON, "older quad retire");
    rt(CRD, "younger quad retire");
    u_lsu.push(48'h0000_0000_0640, SDB_SZ_O, D0);
    ld(48'h0000_0000_0640, SDB_SZ_O, FWD, "single oword");
    chk_data(D0, "single oword");
    $display("test oword done");
  endtask

  task automatic t_bytes();
    rst();
    u_lsu.push(48'h0000_0000_0700, SDB_SZ_B, D0);
    u_lsu.push(48'h0000_0000_0701, SDB_SZ_B, ~D0);
    u_lsu.push(48'h0000_0000_0720, SDB_SZ_B, D0);
    ld(48'h0000_0000_0701, SDB_SZ_B, FWD, "high byte");
    chk_data(msk(~D0, 0, 1), "high byte");
    ld(48'h0000_0000_0720, SDB_SZ_B, FWD, "lone byte");
    chk_data(msk(D0, 0, 1), "lone byte");
    ld(48'h0000_0000_0700, SDB_SZ_B, BLK, "low byte");
    rt(NON, "low byte retire");
    rt(CRD, "high byte retire");
    $display("test split_bytes done");
  endtask

  task automatic t_alias();
    rst();
    u_lsu.push(48'h0001_0000_0800, SDB_SZ_D, D0);
    ld(48'h0002_0000_0800, SDB_SZ_D, CAN, "upper bits differ");
    ld(48'h0001_0000_0810, SDB_SZ_D, CRD, "bits 11:4 differ");
    ld(48'h0001_0000_0804, SDB_SZ_D, CRD, "other dword");
    ld(48'h0001_0000_0800, SDB_SZ_D, FWD, "retry matches");
    chk_data(msk(D0, 0, 4), "retry matches");
    $display("test alias done");
  endtask

  // full buffer refuses a push; slots wrap once one retires
  task automatic t_full();
    rst();
    for (int i = 0; i < SDB_ENTRIES; i++) begin
      u_lsu.push(48'h0000_0000_0b00 + 48'(i * 16), SDB_SZ_D, D0);
    end
    chk_rdy(st_ready, 1'b0, "buffer full");
    u_lsu.push(48'h0000_0000_0c00, SDB_SZ_D, ~D0);
    ld(48'h0000_0000_0b70, SDB_SZ_D, FWD, "last slot");
    chk_data(msk(D0, 0, 4), "last slot");
    ld(48'h0000_0000_0c00, SDB_SZ_D, CRD, "refused store");
    rt(NON, "free one slot");
    chk_rdy(st_ready, 1'b1, "slot free");
    u_lsu.push(48'h0000_0000_0c00, SDB_SZ_D, ~D0);
    ld(48'h0000_0000_0c00, SDB_SZ_D, FWD, "wrapped slot");
    chk_data(msk(~D0, 0, 4), "wrapped slot");
    $display("test full done");
  endtask

  // clock enable low holds result pulses and ignores a push
  task automatic t_freeze();
    rst();
    u_lsu.push(48'h0000_0000_0900, SDB_SZ_D, D0);
    ld(48'h0000_0000_0900, SDB_SZ_D, FWD, "before freeze");
    ce = 1'b0;
    @(negedge sys_clk);
    chk_res({1'b0, fwd_valid, ld_cancel, ld_block, ld_cache_rd}, 5'h08, "held pulse");
    u_lsu.push(48'h0000_0000_0a00, SDB_SZ_D, ~D0);
    ce = 1'b1;
    ld(48'h0000_0000_0a00, SDB_SZ_D, CRD, "frozen push");
    $display("test freeze done");
  endtask

  // blocking store retires in the load's second stage
  task automatic t_race();
    rst();
    u_lsu.push(48'h0000_0000_0d04, SDB_SZ_Q, D0);
    fork
      u_lsu.load(48'h0000_0000_0d04, SDB_SZ_Q, sp);
      begin
        @(negedge sys_clk);
        u_lsu.retire();
      end
    join
    chk_res({sp, fwd_valid, ld_cancel, ld_block, ld_cache_rd}, CRD, "retire in stage 2");
    chk_rdy(ld_ready, 1'b1, "not left waiting");
    $display("test retire_race done");
  endtask

  // whole run is a few hundred cycles; ample margin
  initial begin
    #200_000;
    errors++;
    end_of_test();
  end

  initial begin
    errors    = 0;
    tests_run = 0;
    srst      = 1'b1;
    ce        = 1'b1;
    repeat (20) @(negedge sys_clk);
    srst = 1'b0;
    t_same();
    t_wide();
    t_upper();
    t_block();
    t_oword();
    t_bytes();
    t_alias();
    t_full();
    t_freeze();
    t_race();
    end_of_test();
  end
endmodule
